// file: sdcke_params.svh
// Constants for the command and clock-enable decoder.
// Assumes inclusion by bare name from package and modules.
`ifndef SDCKE_PARAMS_SVH
`define SDCKE_PARAMS_SVH
`define SDCKE_AP_BIT_X32   4'h8
`define SDCKE_AP_BIT_X16   4'hA
`define SDCKE_COL_W_X32    4'h8
`define SDCKE_COL_W_X16    4'h9
`define SDCKE_ROW_W        12
`define SDCKE_ADDR_W       12
`define SDCKE_NBANK        4
`define SDCKE_DQ_W         32
`define SDCKE_LANES        4
`define SDCKE_RFC_W        12
`define SDCKE_MR_BASE      2'h0
`define SDCKE_MR_EXT       2'h1
`endif

// file: sdcke_pkg.sv
// Types shared by the decoder files.
// Assumes sdcke_params.svh is on the include path.
`include "sdcke_params.svh"
package sdcke_pkg;
  // Decoded command codes
  typedef enum logic [3:0] {
    CMD_NOP      = 4'h0,
    CMD_ACTIVE   = 4'h1,
    CMD_READ     = 4'h2,
    CMD_WRITE    = 4'h3,
    CMD_BST      = 4'h4,
    CMD_PRE      = 4'h5,
    CMD_REFRESH  = 4'h6,
    CMD_MRS      = 4'h7,
    CMD_ILLEGAL  = 4'hF
  } sdcke_cmd_t;
  // Power states, Gray coded along the usual path
  typedef enum logic [1:0] {
    PS_NORMAL    = 2'b00,
    PS_PRE_PD    = 2'b01,
    PS_ACT_PD    = 2'b11,
    PS_SELF_REF  = 2'b10
  } sdcke_pwr_t;
endpackage

// file: sdcke_mask.sv
// Per-lane write mask merge: masked byte lanes keep their old content.
// Assumes data and mask come in the same cycle, one mask bit per strobe lane.
`timescale 1ns/100ps
`include "sdcke_params.svh"
module sdcke_mask #(
  parameter int LANES = `SDCKE_LANES
) (
  input  wire logic [LANES*8-1:0] i_old,    // Current stored word
  input  wire logic [LANES*8-1:0] i_new,    // Write data beat
  input  wire logic [LANES-1:0]   i_mask,   // High blocks a lane
  output logic      [LANES*8-1:0] o_merged  // Word to store
);
  // Lane n covers bits 8n to 8n+7, lane 0 lowest
  always_comb begin
    for (int n = 0; n < LANES; n++) begin
      o_merged[n*8 +: 8] = i_mask[n] ? i_old[n*8 +: 8] : i_new[n*8 +: 8];
    end
  end
endmodule // sdcke_mask

// file: sdcke_decoder.sv
// Command decoder and clock-enable power state logic of a four-bank DDR memory.
// Assumes controller drives command, address and CKE synchronous to i_core_clk.
`timescale 1ns/100ps
`include "sdcke_params.svh"
module sdcke_decoder #(
  parameter int  NBANK     = `SDCKE_NBANK,
  parameter int  BURST_LEN = 4,            // Beats per burst, data cycles
  parameter bit  X32       = 1'b1          // High: 32-bit configuration
) (
  input  wire logic                     i_core_clk,     // Device clock
  input  wire logic                     i_rst_n,        // Async reset, low active
  input  wire logic                     i_cs_n,         // Chip select
  input  wire logic                     i_ras_n,        // Row strobe
  input  wire logic                     i_cas_n,        // Column strobe
  input  wire logic                     i_we_n,         // Write enable
  input  wire logic                     i_cke,          // Clock enable
  input  wire logic [1:0]               i_ba,           // Bank address
  input  wire logic [`SDCKE_ADDR_W-1:0] i_addr,         // Address lines
  input  wire logic [`SDCKE_DQ_W-1:0]   i_wdata,        // Write data beat
  input  wire logic [`SDCKE_LANES-1:0]  i_dm,           // Data mask per lane
  output logic      [3:0]               o_cmd,          // Decoded command
  output logic      [1:0]               o_cmd_bank,     // Bank of command
  output logic      [`SDCKE_ROW_W-1:0]  o_row,          // Row of activate
  output logic      [8:0]               o_col,          // Column of access
  output logic                          o_auto_pre,     // Access has auto-precharge
  output logic      [NBANK-1:0]         o_bank_open,    // Open row per bank
  output logic                          o_rd_busy,      // Read burst running
  output logic                          o_wr_busy,      // Write burst running
  output logic                          o_refresh,      // Auto refresh pulse
  output logic      [`SDCKE_RFC_W-1:0]  o_ref_row,      // Internal refresh row
  output logic      [1:0]               o_ref_bank,     // Internal refresh bank
  output logic      [1:0]               o_pwr_state,    // Power state
  output logic                          o_mr_wr,        // Base mode register write
  output logic                          o_emr_wr,       // Extended register write
  output logic      [`SDCKE_ADDR_W-1:0] o_mr_op,        // Loaded base opcode
  output logic      [`SDCKE_ADDR_W-1:0] o_emr_op,       // Loaded extended opcode
  output logic      [`SDCKE_DQ_W-1:0]   o_wr_word,      // Merged stored word
  output logic                          o_wr_strobe     // Word store pulse
);

  // Whole state of the block
  typedef struct packed {
    // Last command and its fields
    logic [3:0]               cmd;
    logic [1:0]               cmd_bank;
    logic [`SDCKE_ROW_W-1:0]  row;
    logic [8:0]               col;
    logic                     auto_pre;
    logic [NBANK-1:0]         bank_open;
    // Burst tracking
    logic [7:0]               burst_cnt;
    logic                     rd_busy;
    logic                     wr_busy;
    logic                     burst_ap;
    logic [1:0]               burst_bank;
    // Refresh counters
    logic                     refresh;
    logic [`SDCKE_RFC_W-1:0]  ref_row;
    logic [1:0]               ref_bank;
    // Power tracking
    sdcke_pkg::sdcke_pwr_t    pwr;
    logic                     cke_prev;
    // Mode registers
    logic                     mr_wr;
    logic                     emr_wr;
    logic [`SDCKE_ADDR_W-1:0] mr_op;
    logic [`SDCKE_ADDR_W-1:0] emr_op;
    // Write path
    logic [`SDCKE_DQ_W-1:0]   store;
    logic [`SDCKE_DQ_W-1:0]   wr_word;
    logic                     wr_strobe;
  } sdcke_state_t;

  sdcke_state_t st_r;          // Registered state
  sdcke_state_t st_nxt;        // Next state
  logic [`SDCKE_DQ_W-1:0] merged; // Mask merge result
  logic self_ref_exit;         // Self refresh exit request, taken at the clock edge

  // Command truth table decode of the four strobes
  function automatic sdcke_pkg::sdcke_cmd_t decode(input logic cs_n, ras_n, cas_n, we_n);
    // Chip select high masks every command
    if (cs_n) begin
      decode = sdcke_pkg::CMD_NOP;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'b111:  decode = sdcke_pkg::CMD_NOP;
        3'b011:  decode = sdcke_pkg::CMD_ACTIVE;
        3'b101:  decode = sdcke_pkg::CMD_READ;
        3'b100:  decode = sdcke_pkg::CMD_WRITE;
        3'b110:  decode = sdcke_pkg::CMD_BST;
        3'b010:  decode = sdcke_pkg::CMD_PRE;
        3'b001:  decode = sdcke_pkg::CMD_REFRESH;
        3'b000:  decode = sdcke_pkg::CMD_MRS;
        // All eight strobe patterns are listed; only unknown values reach the default
        default: decode = sdcke_pkg::CMD_ILLEGAL;
      endcase
    end
  endfunction

  // Auto-precharge bit position by configuration
  function automatic logic ap_bit(input logic [`SDCKE_ADDR_W-1:0] a);
    ap_bit = X32 ? a[`SDCKE_AP_BIT_X32] : a[`SDCKE_AP_BIT_X16];
  endfunction

  // Write data merged against the last stored word
  sdcke_mask #(
    .LANES (`SDCKE_LANES)
  ) u_mask (
    .i_old    (st_r.store),
    .i_new    (i_wdata),
    .i_mask   (i_dm),
    .o_merged (merged)
  );

  // CKE high while in self refresh, sampled at the clock edge
  assign self_ref_exit = i_cke && (st_r.pwr == sdcke_pkg::PS_SELF_REF);

  // Next state logic
  always_comb begin
    sdcke_pkg::sdcke_cmd_t c;
    logic ap;
    c      = decode(i_cs_n, i_ras_n, i_cas_n, i_we_n);
    ap     = ap_bit(i_addr);
    st_nxt = st_r;
    // Pulses default low, command defaults to none
    st_nxt.cke_prev  = i_cke;
    st_nxt.refresh   = 1'b0;
    st_nxt.mr_wr     = 1'b0;
    st_nxt.emr_wr    = 1'b0;
    st_nxt.wr_strobe = 1'b0;
    st_nxt.cmd       = 4'(sdcke_pkg::CMD_NOP);
    // Burst progress; auto-precharge closes the bank at the end
    if (st_r.rd_busy || st_r.wr_busy) begin
      // Each write beat merges into the stored word
      if (st_r.wr_busy) begin
        st_nxt.store     = merged;
        st_nxt.wr_word   = merged;
        st_nxt.wr_strobe = 1'b1;
      end
      // Last beat ends the burst
      if (st_r.burst_cnt == 8'h01) begin
        st_nxt.rd_busy = 1'b0;
        st_nxt.wr_busy = 1'b0;
        if (st_r.burst_ap) begin
          st_nxt.bank_open[st_r.burst_bank] = 1'b0;
        end
      end
      st_nxt.burst_cnt = st_r.burst_cnt - 8'h01;
    end
    // Power state from previous and current CKE
    case (st_r.pwr)
      sdcke_pkg::PS_NORMAL: begin
        // CKE fall: power-down or self refresh entry
        if (st_r.cke_prev && !i_cke) begin
          if (c == sdcke_pkg::CMD_NOP) begin
            st_nxt.pwr = (st_r.bank_open == '0) ? sdcke_pkg::PS_PRE_PD
                                                : sdcke_pkg::PS_ACT_PD;
          end else if (c == sdcke_pkg::CMD_REFRESH) begin
            st_nxt.pwr = sdcke_pkg::PS_SELF_REF;
          end
        end else if (st_r.cke_prev && i_cke) begin
          // Commands act only with CKE high at this and the previous edge
          st_nxt.cmd = 4'(c);
          case (c)
            // Open the addressed row
            sdcke_pkg::CMD_ACTIVE: begin
              st_nxt.cmd_bank = i_ba;
              st_nxt.row      = i_addr;
              st_nxt.bank_open[i_ba] = 1'b1;
            end
            // New access restarts the burst counter
            sdcke_pkg::CMD_READ, sdcke_pkg::CMD_WRITE: begin
              st_nxt.cmd_bank   = i_ba;
              st_nxt.col        = X32 ? {1'b0, i_addr[7:0]} : i_addr[8:0];
              st_nxt.auto_pre   = ap;
              st_nxt.burst_ap   = ap;
              st_nxt.burst_bank = i_ba;
              st_nxt.burst_cnt  = 8'(BURST_LEN);
              st_nxt.rd_busy    = (c == sdcke_pkg::CMD_READ);
              st_nxt.wr_busy    = (c == sdcke_pkg::CMD_WRITE);
            end
            // Only a plain read burst can be cut
            sdcke_pkg::CMD_BST: begin
              if (st_r.rd_busy && !st_r.burst_ap) begin
                st_nxt.rd_busy   = 1'b0;
                st_nxt.burst_cnt = 8'h00;
              end
            end
            // Address bit picks one bank or all
            sdcke_pkg::CMD_PRE: begin
              if (ap) begin
                st_nxt.bank_open = '0;
              end else begin
                st_nxt.bank_open[i_ba] = 1'b0;
              end
            end
            sdcke_pkg::CMD_REFRESH: begin
              // Internal counters pick row and bank
              st_nxt.refresh  = 1'b1;
              st_nxt.ref_bank = st_r.ref_bank + 2'h1;
              // Row steps once every bank is done
              if (st_r.ref_bank == 2'h3) begin
                st_nxt.ref_row = st_r.ref_row + 12'h001;
              end
            end
            // Bank address picks the register
            sdcke_pkg::CMD_MRS: begin
              if (i_ba == `SDCKE_MR_BASE) begin
                st_nxt.mr_wr = 1'b1;
                st_nxt.mr_op = i_addr;
              end else if (i_ba == `SDCKE_MR_EXT) begin
                st_nxt.emr_wr = 1'b1;
                st_nxt.emr_op = i_addr;
              end
            end
            default: begin
              st_nxt.cmd = 4'(c);                   // No operation started
            end
          endcase
        end
      end
      // Power-down: CKE rise with no operation exits
      sdcke_pkg::PS_PRE_PD, sdcke_pkg::PS_ACT_PD: begin
        if (!st_r.cke_prev && i_cke && c == sdcke_pkg::CMD_NOP) begin
          st_nxt.pwr = sdcke_pkg::PS_NORMAL;
        end
      end
      sdcke_pkg::PS_SELF_REF: begin
        // Held while CKE is low; exit taken by the state register at an edge with CKE high
        st_nxt.pwr = sdcke_pkg::PS_SELF_REF;
      end
      // All four codes are used; only an unknown value falls back to normal
      default: begin
        st_nxt.pwr = sdcke_pkg::PS_NORMAL;
      end
    endcase
  end

  // State register; self refresh exit acts at the first clock edge with CKE high
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    // Reset clears every field
    if (!i_rst_n) begin
      st_r     <= '0;
      st_r.pwr <= sdcke_pkg::PS_NORMAL;
    // Leaving self refresh counts CKE as high
    end else if (self_ref_exit) begin
      st_r          <= st_nxt;
      st_r.pwr      <= sdcke_pkg::PS_NORMAL;
      st_r.cke_prev <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign o_cmd       = st_r.cmd;
  assign o_cmd_bank  = st_r.cmd_bank;
  assign o_row       = st_r.row;
  assign o_col       = st_r.col;
  assign o_auto_pre  = st_r.auto_pre;
  assign o_bank_open = st_r.bank_open;
  // Burst and refresh status
  assign o_rd_busy   = st_r.rd_busy;
  assign o_wr_busy   = st_r.wr_busy;
  assign o_refresh   = st_r.refresh;
  assign o_ref_row   = st_r.ref_row;
  assign o_ref_bank  = st_r.ref_bank;
  // Power state and mode registers
  assign o_pwr_state = st_r.pwr;
  assign o_mr_wr     = st_r.mr_wr;
  assign o_emr_wr    = st_r.emr_wr;
  assign o_mr_op     = st_r.mr_op;
  assign o_emr_op    = st_r.emr_op;
  // Write path
  assign o_wr_word   = st_r.wr_word;
  assign o_wr_strobe = st_r.wr_strobe;

endmodule // sdcke_decoder

// file: sdcke_ctrl_model.sv
// Controller stand-in: turns a command code into the four command strobes.
// Assumes the bench changes i_op by non-blocking assignment at the rising edge.
`timescale 1ns/100ps
module sdcke_ctrl_model (
  input  wire logic       i_core_clk, // Device clock
  input  wire logic [3:0] i_op,       // Command code, unknown codes deselect
  output logic            o_cs_n,     // Chip select
  output logic            o_ras_n,    // Row strobe
  output logic            o_cas_n,    // Column strobe
  output logic            o_we_n      // Write enable
);
  logic [2:0] last_r = 3'h0; // Strobes of the previous cycle

  // Remember strobes so a deselect can scramble them
  always_ff @(posedge i_core_clk) begin
    last_r <= {o_ras_n, o_cas_n, o_we_n};
  end

  // Only listed encodings leave the model; they follow i_op from the edge on
  always_comb begin
    o_cs_n = 1'b0;
    case (i_op)
      sdcke_pkg::CMD_NOP:     {o_ras_n, o_cas_n, o_we_n} = 3'h7;
      sdcke_pkg::CMD_ACTIVE:  {o_ras_n, o_cas_n, o_we_n} = 3'h3;
      sdcke_pkg::CMD_READ:    {o_ras_n, o_cas_n, o_we_n} = 3'h5;
      sdcke_pkg::CMD_WRITE:   {o_ras_n, o_cas_n, o_we_n} = 3'h4;
      sdcke_pkg::CMD_BST:     {o_ras_n, o_cas_n, o_we_n} = 3'h6;
      sdcke_pkg::CMD_PRE:     {o_ras_n, o_cas_n, o_we_n} = 3'h2;
      sdcke_pkg::CMD_REFRESH: {o_ras_n, o_cas_n, o_we_n} = 3'h1;
      sdcke_pkg::CMD_MRS:     {o_ras_n, o_cas_n, o_we_n} = 3'h0;
      default: begin
        // Deselect: other strobes are don't care, so they wobble
        o_cs_n = 1'b1;
        {o_ras_n, o_cas_n, o_we_n} = ~last_r;
      end
    endcase
  end
endmodule // sdcke_ctrl_model

// file: sdcke_decoder_props.sv
// Concurrent checks on the decoder ports, attached by bind.
// Assumes sdcke_pkg and the decoder are compiled before it.
`timescale 1ns/100ps
module sdcke_decoder_props #(
  parameter int NBANK = 4,
  parameter bit X32   = 1'b1
) (
  input wire logic             i_core_clk,
  input wire logic             i_rst_n,
  input wire logic             i_cs_n,
  input wire logic             i_ras_n,
  input wire logic             i_cas_n,
  input wire logic             i_we_n,
  input wire logic             i_cke,
  input wire logic [1:0]       i_ba,
  input wire logic [11:0]      i_addr,
  input wire logic [3:0]       i_dm,
  input wire logic [3:0]       o_cmd,
  input wire logic [1:0]       o_cmd_bank,
  input wire logic             o_auto_pre,
  input wire logic [NBANK-1:0] o_bank_open,
  input wire logic             o_rd_busy,
  input wire logic             o_wr_busy,
  input wire logic             o_refresh,
  input wire logic [1:0]       o_pwr_state,
  input wire logic             o_mr_wr,
  input wire logic             o_emr_wr,
  input wire logic [11:0]      o_mr_op,
  input wire logic [11:0]      o_emr_op,
  input wire logic [31:0]      o_wr_word,
  input wire logic             o_wr_strobe
);
  logic       cke_q; // CKE at the previous edge
  logic       ok;    // Command taken at this edge
  logic       ap;    // Auto-precharge bit
  logic       idle;  // Deselect or no-operation
  logic       srf;   // Refresh encoding selected
  logic [2:0] c;     // Row, column, write strobes

  // Track CKE of the previous edge, cleared like the design's copy
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= i_cke;
    end
  end
  assign c    = {i_ras_n, i_cas_n, i_we_n};
  assign ok   = i_cke && cke_q && o_pwr_state == 2'b00 && !i_cs_n;
  assign ap   = X32 ? i_addr[8] : i_addr[10];
  assign idle = i_cs_n || c == 3'h7;
  assign srf  = !i_cs_n && c == 3'h1;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  AST_NOP:
    assert property (idle |=> o_cmd == 4'h0 && !o_mr_wr) else $error("idle cycle decoded");
  AST_ACT:
    assert property (ok && c == 3'h3 |=> o_cmd == 4'h1 && o_bank_open[$past(i_ba)])
    else $error("activate not decoded");
  AST_ACC:
    assert property (ok && c[2:1] == 2'b10 |=> o_cmd == ($past(i_we_n) ? 4'h2 : 4'h3) &&
      o_auto_pre == $past(ap) && o_rd_busy == $past(i_we_n)) else $error("access bad");
  AST_AP:
    assert property (($fell(o_rd_busy) || $fell(o_wr_busy)) && !o_rd_busy && !o_wr_busy &&
      o_cmd != 4'h1 && o_auto_pre |-> !o_bank_open[o_cmd_bank])
    else $error("auto-precharge missed");
  AST_PRE:
    assert property (ok && c == 3'h2 |=> o_cmd == 4'h5 && ($past(ap) ? o_bank_open == '0 :
      !o_bank_open[$past(i_ba)])) else $error("precharge bad");
  AST_REF:
    assert property (ok && c == 3'h1 |=> o_refresh ##0 $stable(o_bank_open))
    else $error("refresh bad");
  AST_MRS:
    assert property (ok && c == 3'h0 && !i_ba[1] |=> ($past(i_ba[0]) ?
      (o_emr_wr && !o_mr_wr && o_emr_op == $past(i_addr)) :
      (o_mr_wr && !o_emr_wr && o_mr_op == $past(i_addr)))) else $error("mode load bad");
  AST_PD_IN:
    assert property (cke_q && !i_cke && o_pwr_state == 2'b00 && (idle || srf) |=>
      o_pwr_state == ($past(srf) ? 2'b10 : (|$past(o_bank_open)) ? 2'b11 : 2'b01))
    else $error("power entry bad");
  AST_PD_HOLD:
    assert property (!cke_q && !i_cke && o_pwr_state != 2'b00 |=> $stable(o_pwr_state) &&
      o_cmd == 4'h0) else $error("power state left");
  AST_PD_OUT:
    assert property (!cke_q && i_cke && o_pwr_state != 2'b00 && idle |=> o_pwr_state == 2'b00)
    else $error("power exit missed");
  AST_MASK:
    assert property (o_wr_busy && i_dm[0] |=> o_wr_strobe && $stable(o_wr_word[7:0]))
    else $error("masked lane written");
endmodule // sdcke_decoder_props

bind sdcke_decoder sdcke_decoder_props #(.NBANK(NBANK), .X32(X32)) u_props (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_ras_n(i_ras_n),
  .i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_cke(i_cke), .i_ba(i_ba), .i_addr(i_addr),
  .i_dm(i_dm), .o_cmd(o_cmd), .o_cmd_bank(o_cmd_bank), .o_auto_pre(o_auto_pre),
  .o_bank_open(o_bank_open), .o_rd_busy(o_rd_busy), .o_wr_busy(o_wr_busy),
  .o_refresh(o_refresh), .o_pwr_state(o_pwr_state), .o_mr_wr(o_mr_wr),
  .o_emr_wr(o_emr_wr), .o_mr_op(o_mr_op), .o_emr_op(o_emr_op), .o_wr_word(o_wr_word),
  .o_wr_strobe(o_wr_strobe));

// file: testbench.sv
// Self-checking bench for the command and clock-enable decoder.
// Assumes package, decoder, controller model and checker are compiled first.
`timescale 1ns/100ps
module testbench;
  localparam int SELF_REFRESH_EXIT_WAIT = 10; // Idle cycles after each power state exit
  logic        i_core_clk = 1'b0;  // Device clock
  logic        i_rst_n    = 1'b0;  // Reset, low active
  logic        i_cke      = 1'b0;  // Clock enable
  logic [3:0]  op         = 4'hE;  // Command to the model
  logic [1:0]  i_ba       = 2'h0;  // Bank address
  logic [11:0] i_addr     = 12'h0; // Address lines
  logic [31:0] i_wdata    = 32'h0; // Write beat
  logic [3:0]  i_dm       = 4'h0;  // Lane mask
  logic        i_cs_n, i_ras_n, i_cas_n, i_we_n;
  logic [3:0]  o_cmd, o_bank_open, sm;
  logic [1:0]  o_cmd_bank, o_ref_bank, o_pwr_state, b;
  logic [11:0] o_row, o_ref_row, o_mr_op, o_emr_op, a, mo, eo;
  logic [8:0]  o_col;
  logic [31:0] o_wr_word, sd, ew;
  logic        o_auto_pre, o_rd_busy, o_wr_busy, o_refresh, o_mr_wr, o_emr_wr, o_wr_strobe;
  int          fail_count = 0;     // Mismatches
  int          n_tests    = 0;     // Comparisons

  always #50 i_core_clk = ~i_core_clk;
  sdcke_ctrl_model u_ctrl (.i_core_clk(i_core_clk), .i_op(op), .o_cs_n(i_cs_n),
    .o_ras_n(i_ras_n), .o_cas_n(i_cas_n), .o_we_n(i_we_n));
  sdcke_decoder #(.BURST_LEN(4), .X32(1'b1)) dut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_ras_n(i_ras_n),
    .i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_cke(i_cke), .i_ba(i_ba), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_dm(i_dm), .o_cmd(o_cmd), .o_cmd_bank(o_cmd_bank), .o_row(o_row),
    .o_col(o_col), .o_auto_pre(o_auto_pre), .o_bank_open(o_bank_open),
    .o_rd_busy(o_rd_busy), .o_wr_busy(o_wr_busy), .o_refresh(o_refresh),
    .o_ref_row(o_ref_row), .o_ref_bank(o_ref_bank), .o_pwr_state(o_pwr_state),
    .o_mr_wr(o_mr_wr), .o_emr_wr(o_emr_wr), .o_mr_op(o_mr_op), .o_emr_op(o_emr_op),
    .o_wr_word(o_wr_word), .o_wr_strobe(o_wr_strobe));

  // Expected word after a beat: masked lanes keep the old byte
  function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] m);
    for (int l = 0; l < 4; l++) merge[l*8+:8] = m[l] ? o[l*8+:8] : n[l*8+:8];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Present one command at an edge; keep the beat sampled there in sd, sm
  task automatic drv(input logic [3:0] o, input logic [1:0] bk, input logic [11:0] ad,
                     input logic k);
    @(posedge i_core_clk);
    sd = i_wdata;
    sm = i_dm;
    op <= o;
    i_ba <= bk;
    i_addr <= ad;
    i_cke <= k;
    i_wdata <= $urandom;
    i_dm <= 4'($urandom);
    #1;
  endtask
  task automatic nop(input logic k);
    drv($urandom_range(1) ? 4'h0 : 4'hE, 2'($urandom), 12'($urandom), k);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (3000) @(posedge i_core_clk);
    fail_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    void'($urandom(3431));
    ew = 32'h0;
    mo = 12'h0;
    eo = 12'h0;
    repeat (5) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    nop(1'b1);
    for (int t = 0; t < 8; t++) begin
      b = 2'($urandom);
      a = {3'($urandom), t[0], 8'($urandom)};
      drv(sdcke_pkg::CMD_ACTIVE, b, a, 1'b1);
      nop(1'b1);
      chk(o_cmd, 4'h1);
      chk(o_row, a);
      chk(o_cmd_bank, b);
      drv(sdcke_pkg::CMD_READ, b, a & 12'hEFF, 1'b1);
      nop(1'b1);
      chk(o_auto_pre, 1'b0);
      drv(sdcke_pkg::CMD_BST, b, a, 1'b1);
      nop(1'b1);
      chk(o_rd_busy, 1'b0);
      drv(sdcke_pkg::CMD_WRITE, b, a, 1'b1);
      for (int i = 1; i < 6; i++) begin
        nop(1'b1);
        if (i == 1) begin
          chk(o_cmd, 4'h3);
          chk(o_col, {1'b0, a[7:0]});
        end else begin
          ew = merge(ew, sd, sm);
          chk(o_wr_word, ew);
        end
      end
      chk(o_bank_open[b], !a[8]);
      if (!a[8]) begin
        drv(sdcke_pkg::CMD_READ, b, a | 12'h100, 1'b1);
        repeat (5) nop(1'b1);
        chk(o_bank_open[b], 1'b0);
      end
    end
    $display("burst test done");
    for (int k = 0; k < 4; k++) drv(sdcke_pkg::CMD_ACTIVE, 2'(k), a, 1'b1);
    b = 2'($urandom);
    drv(sdcke_pkg::CMD_PRE, b, 12'h0FF, 1'b1);
    nop(1'b1);
    chk(o_bank_open, 4'hF ^ (4'h1 << b));
    drv(sdcke_pkg::CMD_PRE, b, 12'h100, 1'b1);
    drv(sdcke_pkg::CMD_REFRESH, b, 12'($urandom), 1'b1);
    chk(o_bank_open, 4'h0);
    nop(1'b1);
    chk(o_cmd, 4'h6);
    chk({o_refresh, o_ref_row, o_ref_bank}, 32'h4001);
    $display("bank test done");
    for (int k = 0; k < 4; k++) begin
      a = 12'($urandom);
      drv(sdcke_pkg::CMD_MRS, 2'(k), a, 1'b1);
      nop(1'b1);
      if (k == 0) mo = a;
      if (k == 1) eo = a;
      chk({o_mr_wr, o_emr_wr}, k == 0 ? 2'h2 : k == 1 ? 2'h1 : 2'h0);
      chk({o_mr_op, o_emr_op}, {mo, eo});
    end
    $display("mode test done");
    for (int j = 0; j < 3; j++) begin
      drv(j != 0 ? sdcke_pkg::CMD_PRE : sdcke_pkg::CMD_ACTIVE, b, 12'hFFF, 1'b1);
      drv(j == 2 ? sdcke_pkg::CMD_REFRESH : sdcke_pkg::CMD_NOP, b, a, 1'b0);
      drv(sdcke_pkg::CMD_ACTIVE, b, a, 1'b0);
      chk(o_pwr_state, j == 0 ? 2'b11 : j == 1 ? 2'b01 : 2'b10);
      nop(1'b0);
      chk(o_cmd, 4'h0);
      chk(o_pwr_state, j == 0 ? 2'b11 : j == 1 ? 2'b01 : 2'b10);
      nop(1'b1);
      nop(1'b1);
      chk(o_pwr_state, 2'b00);
      repeat (SELF_REFRESH_EXIT_WAIT) nop(1'b1);
    end
    $display("power test done");
    give_verdict();
  end
endmodule // testbench
